// ---- src/dprp_pkg.sv ----
// Constants and types shared by the two-port RAM block.
package dprp_pkg;

  // AXI4-Lite register map, byte addresses.
  localparam int          DPRP_AXI_AW     = 4;
  localparam logic [3:0]  DPRP_OFS_CFG    = 4'h0;
  localparam logic [3:0]  DPRP_OFS_STATUS = 4'h4;
  localparam logic [1:0]  DPRP_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  DPRP_RESP_SLVERR = 2'h2;

  // Configuration register fields.
  localparam int DPRP_CFG_FORM     = 0;
  localparam int DPRP_CFG_OP_LSB   = 1;
  localparam int DPRP_CFG_OP_MSB   = 2;
  localparam int DPRP_CFG_CK_LSB   = 3;
  localparam int DPRP_CFG_CK_MSB   = 4;
  localparam int DPRP_CFG_OUTREG_A = 5;
  localparam int DPRP_CFG_OUTREG_B = 6;
  localparam int DPRP_CFG_USE_BE   = 7;
  localparam int DPRP_CFG_LE_IMPL  = 8;
  localparam int DPRP_CFG_USE_RDEN = 9;
  localparam int DPRP_CFG_USE_EAB  = 10;
  localparam int DPRP_CFG_OLD_DATA = 11;
  localparam int DPRP_CFG_USE_CKEN = 12;
  localparam int DPRP_CFG_BITS     = 13;
  localparam logic [31:0] DPRP_CFG_RESET = 32'h0000_0800;

  // Status register fields: write counters of port A and port B.
  localparam int DPRP_CNT_W       = 16;
  localparam int DPRP_STS_CNTA_LSB = 0;
  localparam int DPRP_STS_CNTB_LSB = 16;

  typedef enum logic [1:0] {
    DPRP_OP_SINGLE,
    DPRP_OP_DUAL,
    DPRP_OP_FULL_TWO_PORT_USAGE,
    DPRP_OP_ROM
  } dprp_opmode_e;

  typedef enum logic [1:0] {
    DPRP_CK_SINGLE,
    DPRP_CK_READ_WRITE,
    DPRP_CK_IN_OUT,
    DPRP_CK_INDEPENDENT
  } dprp_clkmode_e;

endpackage

// ---- src/dprp_top.sv ----
// Two-port synchronous RAM with AXI4-Lite configuration and status.
//
// Summary of operation
// - Simple or true dual-port arrangement.
// - Simple form: write and read data equal width.
// - Simple form: write and read address equal width.
// - Simple form: writes qualified by write strobe.
// - Single clock mode: one clock for all.
// - Read/write mode: write side, read side groups.
// - Input/output mode: inputs input, output register output.
// - Independent mode: port A separate from port B.
// - Simple form: optional read strobe qualifies reads.
// - Simple read strobe only without embedded-array usage.
// - Byte enables write only enabled lanes.
// - No byte enables for logic or read-only.
// - Clock enables suppress updates of their groups.
// - Port A address used in every mode.
// - Port A write in single, dual, full modes.
// - Port B write only in full two-port usage.
// - Port B address in dual and full modes.
// - Port A address hold keeps old address.
// - Port B address hold keeps old address.
// - Per-port read strobes qualify port reads.
// - Port A output in single, full, read-only.
// - Port B output in dual and full modes.
// - Old-contents option returns pre-write value.
`timescale 1ns/1ns
module dprp_top #(
  parameter int DEPTH  = 256, // Words of storage.
  parameter int DATA_W = 32,  // Data width of both ports.
  parameter int BE_W   = 4    // Byte enable lanes per word.
) (
  input  wire logic                            clk_sys_i,         // Clock.
  input  wire logic                            resetn_i,          // Reset.
  input  wire logic [$clog2(DEPTH)-1:0]        addr_a_i,          // A addr.
  input  wire logic [DATA_W-1:0]               wdata_a_i,         // A data.
  input  wire logic                            wren_a_i,          // A write.
  input  wire logic                            rden_a_i,          // A read.
  input  wire logic [BE_W-1:0]                 byteena_a_i,       // A lanes.
  input  wire logic                            addrstall_a_i,     // A hold.
  input  wire logic [$clog2(DEPTH)-1:0]        addr_b_i,          // B addr.
  input  wire logic [DATA_W-1:0]               wdata_b_i,         // B data.
  input  wire logic                            wren_b_i,          // B write.
  input  wire logic                            rden_b_i,          // B read.
  input  wire logic [BE_W-1:0]                 byteena_b_i,       // B lanes.
  input  wire logic                            addrstall_b_i,     // B hold.
  input  wire logic                            in_clken_i,        // In CE.
  input  wire logic                            out_clken_i,       // Out CE.
  output logic      [DATA_W-1:0]               q_a_o,             // A out.
  output logic      [DATA_W-1:0]               q_b_o,             // B out.
  input  wire logic [dprp_pkg::DPRP_AXI_AW-1:0] s_axi_awaddr_i,   // AW addr.
  input  wire logic                            s_axi_awvalid_i,   // AW valid.
  output logic                                 s_axi_awready_o,   // AW ready.
  input  wire logic [31:0]                     s_axi_wdata_i,     // W data.
  input  wire logic [3:0]                      s_axi_wstrb_i,     // W strobes.
  input  wire logic                            s_axi_wvalid_i,    // W valid.
  output logic                                 s_axi_wready_o,    // W ready.
  output logic      [1:0]                      s_axi_bresp_o,     // B resp.
  output logic                                 s_axi_bvalid_o,    // B valid.
  input  wire logic                            s_axi_bready_i,    // B ready.
  input  wire logic [dprp_pkg::DPRP_AXI_AW-1:0] s_axi_araddr_i,   // AR addr.
  input  wire logic                            s_axi_arvalid_i,   // AR valid.
  output logic                                 s_axi_arready_o,   // AR ready.
  output logic      [31:0]                     s_axi_rdata_o,     // R data.
  output logic      [1:0]                      s_axi_rresp_o,     // R resp.
  output logic                                 s_axi_rvalid_o,    // R valid.
  input  wire logic                            s_axi_rready_i     // R ready.
);

  localparam int AW     = $clog2(DEPTH);
  localparam int LANE_W = DATA_W / BE_W;

  logic [DATA_W-1:0]                   mem [DEPTH];
  logic [31:0]                         cfg_reg;
  logic [dprp_pkg::DPRP_CNT_W-1:0]     wcnt_a_reg;
  logic [dprp_pkg::DPRP_CNT_W-1:0]     wcnt_b_reg;
  logic [AW-1:0]                       addr_a_reg;
  logic [AW-1:0]                       addr_b_reg;
  logic                                rd_a_reg;
  logic                                rd_b_reg;
  logic [DATA_W-1:0]                   q1_a_reg;
  logic [DATA_W-1:0]                   q1_b_reg;
  logic [dprp_pkg::DPRP_AXI_AW-1:0]    aw_addr_reg;
  logic [31:0]                         w_data_reg;
  logic [3:0]                          w_strb_reg;

  // Replaces the enabled lanes of a stored word with new data.
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [BE_W-1:0]   be,
    input logic              use_be
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < DATA_W; i++) begin
      if (!use_be || be[i / LANE_W]) begin
        res[i] = new_w[i];
      end
    end
    return res;
  endfunction

  // Maps the clock mode onto enables of the six register groups:
  // {A inputs, A array read, A output, B inputs, B array read, B output}.
  function automatic logic [5:0] group_en(
    input dprp_pkg::dprp_clkmode_e mode,
    input logic                    ice,
    input logic                    oce
  );
    logic [5:0] res;
    res = {6{ice}};
    unique case (mode)
      dprp_pkg::DPRP_CK_SINGLE:      res = {6{ice}};
      dprp_pkg::DPRP_CK_READ_WRITE:  res = {ice, oce, oce, oce, oce, oce};
      dprp_pkg::DPRP_CK_IN_OUT:      res = {ice, ice, oce, ice, ice, oce};
      dprp_pkg::DPRP_CK_INDEPENDENT: res = {ice, ice, ice, oce, oce, oce};
    endcase
    return res;
  endfunction

  // Configuration decode.
  dprp_pkg::dprp_opmode_e  opmode;
  dprp_pkg::dprp_clkmode_e clkmode;
  logic form_true;
  logic is_rom;
  logic a_wr_ok;
  logic a_rd_ok;
  logic b_wr_ok;
  logic b_rd_ok;
  logic rden_use;
  logic be_use;
  logic in_ce;
  logic out_ce;
  logic [5:0] gen;
  logic en_a_in;
  logic en_a_st;
  logic en_a_out;
  logic en_b_in;
  logic en_b_st;
  logic en_b_out;

  always_comb begin
    opmode  = dprp_pkg::dprp_opmode_e'(
      cfg_reg[dprp_pkg::DPRP_CFG_OP_MSB:dprp_pkg::DPRP_CFG_OP_LSB]);
    clkmode = dprp_pkg::dprp_clkmode_e'(
      cfg_reg[dprp_pkg::DPRP_CFG_CK_MSB:dprp_pkg::DPRP_CFG_CK_LSB]);
    form_true = cfg_reg[dprp_pkg::DPRP_CFG_FORM];
    is_rom    = form_true && (opmode == dprp_pkg::DPRP_OP_ROM);
    a_wr_ok = !is_rom;
    a_rd_ok = form_true && (opmode != dprp_pkg::DPRP_OP_DUAL);
    b_wr_ok = form_true &&
              (opmode == dprp_pkg::DPRP_OP_FULL_TWO_PORT_USAGE);
    b_rd_ok = !form_true || (opmode == dprp_pkg::DPRP_OP_DUAL) ||
              (opmode == dprp_pkg::DPRP_OP_FULL_TWO_PORT_USAGE);
    rden_use = cfg_reg[dprp_pkg::DPRP_CFG_USE_RDEN] &&
               (form_true || !cfg_reg[dprp_pkg::DPRP_CFG_USE_EAB]);
    be_use = cfg_reg[dprp_pkg::DPRP_CFG_USE_BE] &&
             !cfg_reg[dprp_pkg::DPRP_CFG_LE_IMPL] && !is_rom;
    in_ce  = !cfg_reg[dprp_pkg::DPRP_CFG_USE_CKEN] || in_clken_i;
    out_ce = !cfg_reg[dprp_pkg::DPRP_CFG_USE_CKEN] || out_clken_i;
    gen = group_en(clkmode, in_ce, out_ce);
    {en_a_in, en_a_st, en_a_out, en_b_in, en_b_st, en_b_out} = gen;
  end

  logic [AW-1:0] addr_a_eff;
  logic [AW-1:0] addr_b_eff;
  assign addr_a_eff = addrstall_a_i ? addr_a_reg : addr_a_i;
  assign addr_b_eff = addrstall_b_i ? addr_b_reg : addr_b_i;

  logic we_a;
  logic we_b;
  assign we_a = en_a_in && wren_a_i && a_wr_ok;
  assign we_b = en_b_in && wren_b_i && b_wr_ok;

  // masked lanes kept
  // Port B is written last, so it wins a same-address collision.
  always_ff @(posedge clk_sys_i) begin
    if (we_a) begin
      mem[addr_a_eff] <= lane_merge(mem[addr_a_eff], wdata_a_i,
                                    byteena_a_i, be_use);
    end
    if (we_b) begin
      mem[addr_b_eff] <= lane_merge(mem[addr_b_eff], wdata_b_i,
                                    byteena_b_i, be_use);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      addr_a_reg <= '0;
      rd_a_reg   <= 1'b0;
    end else if (en_a_in) begin
      if (!addrstall_a_i) begin
        addr_a_reg <= addr_a_i;
      end
      rd_a_reg <= a_rd_ok && (!rden_use || rden_a_i);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      addr_b_reg <= '0;
      rd_b_reg   <= 1'b0;
    end else if (en_b_in) begin
      if (!addrstall_b_i) begin
        addr_b_reg <= addr_b_i;
      end
      rd_b_reg <= b_rd_ok && (!rden_use || rden_b_i);
    end
  end

  // old contents or bypass
  // Without the old-contents option a colliding write from the other
  // port is forwarded, so the read shows the new word.
  logic old_data;
  logic [DATA_W-1:0] rdval_a;
  logic [DATA_W-1:0] rdval_b;
  always_comb begin
    old_data = cfg_reg[dprp_pkg::DPRP_CFG_OLD_DATA];
    rdval_a  = mem[addr_a_reg];
    rdval_b  = mem[addr_b_reg];
    if (!old_data && we_b && (addr_b_eff == addr_a_reg)) begin
      rdval_a = lane_merge(mem[addr_a_reg], wdata_b_i, byteena_b_i, be_use);
    end
    if (!old_data && we_a && (addr_a_eff == addr_b_reg)) begin
      rdval_b = lane_merge(mem[addr_b_reg], wdata_a_i, byteena_a_i, be_use);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      q1_a_reg <= '0;
      q1_b_reg <= '0;
    end else begin
      if (en_a_st && rd_a_reg) begin
        q1_a_reg <= rdval_a;
      end
      if (en_b_st && rd_b_reg) begin
        q1_b_reg <= rdval_b;
      end
    end
  end

  // port A and port B outputs
  // Without an output register the output flop loads with the first stage.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      q_a_o <= '0;
      q_b_o <= '0;
    end else begin
      if (cfg_reg[dprp_pkg::DPRP_CFG_OUTREG_A]) begin
        if (en_a_out) begin
          q_a_o <= q1_a_reg;
        end
      end else if (en_a_st && rd_a_reg) begin
        q_a_o <= rdval_a;
      end
      if (cfg_reg[dprp_pkg::DPRP_CFG_OUTREG_B]) begin
        if (en_b_out) begin
          q_b_o <= q1_b_reg;
        end
      end else if (en_b_st && rd_b_reg) begin
        q_b_o <= rdval_b;
      end
    end
  end

  // AXI4-Lite write path: address and data are taken in either order,
  // the register write happens once both are held and no response waits.
  logic wr_go;
  logic clr_cnt;
  assign wr_go   = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign clr_cnt = wr_go && (aw_addr_reg == dprp_pkg::DPRP_OFS_STATUS);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= dprp_pkg::DPRP_RESP_OKAY;
      aw_addr_reg     <= '0;
      w_data_reg      <= '0;
      w_strb_reg      <= '0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr_reg     <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data_reg     <= s_axi_wdata_i;
        w_strb_reg     <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        if ((aw_addr_reg == dprp_pkg::DPRP_OFS_CFG) ||
            (aw_addr_reg == dprp_pkg::DPRP_OFS_STATUS)) begin
          s_axi_bresp_o <= dprp_pkg::DPRP_RESP_OKAY;
        end else begin
          s_axi_bresp_o <= dprp_pkg::DPRP_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Configuration register; bits above the defined fields read as zero.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cfg_reg <= dprp_pkg::DPRP_CFG_RESET;
    end else if (wr_go && (aw_addr_reg == dprp_pkg::DPRP_OFS_CFG)) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_reg[b]) begin
          cfg_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
        end
      end
      cfg_reg[31:dprp_pkg::DPRP_CFG_BITS] <= '0;
    end
  end

  // Write counters; a write landing with the clear still counts.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wcnt_a_reg <= '0;
      wcnt_b_reg <= '0;
    end else if (clr_cnt) begin
      wcnt_a_reg <= {{(dprp_pkg::DPRP_CNT_W-1){1'b0}}, we_a};
      wcnt_b_reg <= {{(dprp_pkg::DPRP_CNT_W-1){1'b0}}, we_b};
    end else begin
      wcnt_a_reg <= wcnt_a_reg + {{(dprp_pkg::DPRP_CNT_W-1){1'b0}}, we_a};
      wcnt_b_reg <= wcnt_b_reg + {{(dprp_pkg::DPRP_CNT_W-1){1'b0}}, we_b};
    end
  end

  // AXI4-Lite read path: one cycle from address handshake to data.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= dprp_pkg::DPRP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rresp_o   <= dprp_pkg::DPRP_RESP_OKAY;
        if (s_axi_araddr_i == dprp_pkg::DPRP_OFS_CFG) begin
          s_axi_rdata_o <= cfg_reg;
        end else if (s_axi_araddr_i == dprp_pkg::DPRP_OFS_STATUS) begin
          s_axi_rdata_o <= {wcnt_b_reg, wcnt_a_reg};
        end else begin
          s_axi_rdata_o <= '0;
          s_axi_rresp_o <= dprp_pkg::DPRP_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

endmodule

// ---- test/dprp_assertions.sv ----
// Checker of register-port timing and RAM output holding rules.
`timescale 1ns/1ns
module dprp_checker #(
  parameter int DATA_W = 32 // Data width.
) (
  input wire logic              clk_sys_i,       // Clock.
  input wire logic              resetn_i,        // Reset.
  input wire logic              wren_a_i,        // A write.
  input wire logic              wren_b_i,        // B write.
  input wire logic              rden_b_i,        // B read.
  input wire logic              addrstall_b_i,   // B hold.
  input wire logic              in_clken_i,      // In CE.
  input wire logic [DATA_W-1:0] q_a_o,           // A out.
  input wire logic [DATA_W-1:0] q_b_o,           // B out.
  input wire logic [3:0]        s_axi_awaddr_i,  // AW addr.
  input wire logic              s_axi_awvalid_i, // AW valid.
  input wire logic              s_axi_awready_o, // AW ready.
  input wire logic [31:0]       s_axi_wdata_i,   // W data.
  input wire logic              s_axi_wvalid_i,  // W valid.
  input wire logic              s_axi_wready_o,  // W ready.
  input wire logic              s_axi_bvalid_o,  // B valid.
  input wire logic              s_axi_bready_i,  // B ready.
  input wire logic [3:0]        s_axi_araddr_i,  // AR addr.
  input wire logic              s_axi_arvalid_i, // AR valid.
  input wire logic              s_axi_arready_o, // AR ready.
  input wire logic [31:0]       s_axi_rdata_o,   // R data.
  input wire logic [1:0]        s_axi_rresp_o,   // R resp.
  input wire logic              s_axi_rvalid_o   // R valid.
);
  default clocking dcb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic [12:0] cfg_q;
  logic        ok;
  // Shadow of the configuration; assumes address and data offered together.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i)
      cfg_q <= 13'h0800;
    else if (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
             s_axi_wready_o && s_axi_awaddr_i == 4'h0)
      cfg_q <= s_axi_wdata_i[12:0];
  end
  assign ok = s_axi_awready_o;
  wr_resp_lat_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write response not two cycles after handshake");
  wr_resp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o) else $error("write response dropped early");
  wr_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o &&
    !s_axi_wready_o) else $error("write ready high while pending");
  rd_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read data late");
  rd_unmapped_a: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i != 4'h0 && s_axi_araddr_i != 4'h4 |=>
    s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  reset_out_a: assert property ($rose(resetn_i) |-> q_a_o == '0 &&
    q_b_o == '0 && s_axi_awready_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("outputs not at reset values");
  q_a_simple_a: assert property (
    ok && !cfg_q[0] |=> $stable(q_a_o)) else $error("q_a moved in simple form");
  cken_freeze_a: assert property (
    ok && cfg_q[12] && cfg_q[4:3] == 2'h0 && !cfg_q[6] && !in_clken_i
    |=> $stable(q_b_o)) else $error("q_b moved with clock enable low");
  rden_hold_a: assert property (
    ok && !cfg_q[0] && cfg_q[9] && !cfg_q[10] && !cfg_q[6] && !cfg_q[12] &&
    !rden_b_i |-> ##2 $stable(q_b_o)) else $error("q_b moved with strobe low");
  stall_hold_a: assert property (
    ok && !cfg_q[0] && !cfg_q[6] && !cfg_q[9] && !cfg_q[12] && addrstall_b_i
    ##1 addrstall_b_i && !wren_a_i && !wren_b_i |-> ##2 $stable(q_b_o))
    else $error("q_b moved with address held");
endmodule
bind dprp_top dprp_checker #(.DATA_W(DATA_W)) dprp_checker_inst (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wren_a_i(wren_a_i),
  .wren_b_i(wren_b_i), .rden_b_i(rden_b_i), .addrstall_b_i(addrstall_b_i),
  .in_clken_i(in_clken_i), .q_a_o(q_a_o), .q_b_o(q_b_o),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o));

// ---- test/dprp_user_model.sv ----
// Model of the user logic that drives the RAM address and data ports.
`timescale 1ns/1ns
module dprp_user_model (
  input  wire logic        clk_i,     // Clock.
  output logic      [7:0]  addr_a_o,  // A addr.
  output logic      [31:0] wdata_a_o, // A data.
  output logic             wren_a_o,  // A write.
  output logic      [7:0]  addr_b_o,  // B addr.
  output logic      [31:0] wdata_b_o, // B data.
  output logic             wren_b_o   // B write.
);
  initial begin
    {addr_a_o, addr_b_o, wren_a_o, wren_b_o} = 18'h0;
    {wdata_a_o, wdata_b_o} = 64'h0;
  end
  // One access per port; unused write data turns to garbage afterwards.
  task automatic op(input logic wa, input logic [7:0] aa,
                    input logic [31:0] da, input logic wb,
                    input logic [7:0] ab, input logic [31:0] db);
    @(posedge clk_i);
    {wren_a_o, addr_a_o, wdata_a_o} <= {wa, aa, da};
    {wren_b_o, addr_b_o, wdata_b_o} <= {wb, ab, db};
    @(posedge clk_i);
    {wren_a_o, wren_b_o} <= 2'b00;
    {wdata_a_o, wdata_b_o} <= ~{da, db};
    @(posedge clk_i);
    #1;
  endtask
endmodule

// ---- test/tb_dprp_top.sv ----
// Self-checking bench of the two-port RAM block and its register port.
`timescale 1ns/1ns
module tb_dprp_top;
  logic        clk_sys_i, resetn_i, rden_a, rden_b, st_a, st_b, ice, oce;
  logic        wren_a, wren_b, awready, wready, bvalid, arready, rvalid;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  addr_a, addr_b;
  logic [3:0]  be_a, be_b, awaddr, araddr, wstrb;
  logic [31:0] wdata_a, wdata_b, q_a_o, q_b_o, wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          bad_count, checks_done;
  dprp_user_model usr (.clk_i(clk_sys_i), .addr_a_o(addr_a),
    .wdata_a_o(wdata_a), .wren_a_o(wren_a), .addr_b_o(addr_b),
    .wdata_b_o(wdata_b), .wren_b_o(wren_b));
  dprp_top dprp_top_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .addr_a_i(addr_a), .wdata_a_i(wdata_a), .wren_a_i(wren_a),
    .rden_a_i(rden_a), .byteena_a_i(be_a), .addrstall_a_i(st_a),
    .addr_b_i(addr_b), .wdata_b_i(wdata_b), .wren_b_i(wren_b),
    .rden_b_i(rden_b), .byteena_b_i(be_b), .addrstall_b_i(st_b),
    .in_clken_i(ice), .out_clken_i(oce), .q_a_o(q_a_o), .q_b_o(q_b_o),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge clk_sys_i);
    {awaddr, wdata} <= {a, dat};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(aw && w)) begin
      @(posedge clk_sys_i);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge clk_sys_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys_i); while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic wcfg(input logic [31:0] v);
    axi_wr(4'h0, v);
    chk("cfg resp", {30'h0, r}, 32'h0);
  endtask
  task automatic rdb(input logic [7:0] a);
    usr.op(1'b0, a, 32'h0, 1'b0, a, 32'h0);
  endtask
  task automatic wra(input logic [7:0] a, input logic [31:0] v);
    usr.op(1'b1, a, v, 1'b0, a, 32'h0);
  endtask
  // Looks at port B in the cycle in which a write to its address lands.
  task automatic clash(input logic [7:0] a, input logic [31:0] v,
                       input logic [31:0] exp);
    fork
      wra(a, v);
      begin
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("clash", q_b_o, exp);
      end
    join
  endtask
  task automatic pin(input int k, input logic v);
    @(posedge clk_sys_i);
    case (k)
      0: st_a <= v;
      1: st_b <= v;
      2: ice <= v;
      4: oce <= v;
      5: rden_a <= v;
      default: rden_b <= v;
    endcase
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  initial begin
    {resetn_i, rden_a, rden_b, st_a, st_b, ice, oce} = 7'b0110011;
    {be_a, be_b, wstrb, awaddr, araddr} = 20'hFFF00;
    {awvalid, wvalid, bready, arvalid, rready, wdata} = 37'h0;
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    axi_rd(4'h0);
    chk("cfg reset", d, 32'h0000_0800);
    axi_rd(4'h8);
    chk("hole data", d, 32'h0);
    chk("hole resp", {30'h0, r}, 32'h2);
    axi_wr(4'hC, 32'h0);
    chk("hole write", {30'h0, r}, 32'h2);
    wra(8'h05, 32'hA5A5_0001);
    clash(8'h05, 32'hA5A5_0002, 32'hA5A5_0001);
    usr.op(1'b0, 8'h05, 32'hDEAD_0003, 1'b0, 8'h05, 32'h0);
    chk("new data", q_b_o, 32'hA5A5_0002);
    rdb(8'h05);
    chk("no strobe", q_b_o, 32'hA5A5_0002);
    chk("a idle", q_a_o, 32'h0);
    axi_rd(4'h4);
    chk("wr count", d, 32'h2);
    axi_wr(4'h4, 32'h0);
    axi_rd(4'h4);
    chk("count clr", d, 32'h0);
    pin(1, 1'b1);
    wra(8'h06, 32'h6666_0004);
    chk("b hold", q_b_o, 32'hA5A5_0002);
    pin(1, 1'b0);
    pin(0, 1'b1);
    wra(8'h07, 32'h7777_0005);
    pin(0, 1'b0);
    rdb(8'h06);
    chk("a hold", q_b_o, 32'h7777_0005);
    wcfg(32'h0000_0880);
    be_a <= 4'h3;
    wra(8'h06, 32'h1111_2222);
    rdb(8'h06);
    chk("lanes", q_b_o, 32'h7777_2222);
    wcfg(32'h0000_0980);
    wra(8'h06, 32'h3333_4444);
    rdb(8'h06);
    chk("le whole", q_b_o, 32'h3333_4444);
    wcfg(32'h0000_1800);
    pin(2, 1'b0);
    wra(8'h06, 32'h5555_6666);
    pin(2, 1'b1);
    rdb(8'h06);
    chk("ce freeze", q_b_o, 32'h3333_4444);
    wcfg(32'h0000_0A00);
    pin(3, 1'b0);
    rdb(8'h05);
    chk("rd strobe", q_b_o, 32'h3333_4444);
    pin(3, 1'b1);
    wcfg(32'h0000_0E00);
    pin(3, 1'b0);
    rdb(8'h06);
    chk("eab strobe", q_b_o, 32'h3333_4444);
    pin(3, 1'b1);
    wcfg(32'h0000_0840);
    rdb(8'h05);
    chk("out reg 1", q_b_o, 32'h3333_4444);
    @(posedge clk_sys_i);
    #1;
    chk("out reg 2", q_b_o, 32'hA5A5_0002);
    wcfg(32'h0000_0805);
    usr.op(1'b0, 8'h08, 32'h0, 1'b1, 8'h08, 32'hB8B8_0006);
    rdb(8'h08);
    chk("b write", q_a_o, 32'hB8B8_0006);
    chk("b read", q_b_o, 32'hB8B8_0006);
    wcfg(32'h0000_0A05);
    pin(5, 1'b0);
    rdb(8'h05);
    chk("a strobe", q_a_o, 32'hB8B8_0006);
    pin(5, 1'b1);
    wcfg(32'h0000_0803);
    wra(8'h09, 32'hA9A9_0007);
    usr.op(1'b0, 8'h09, 32'h0, 1'b1, 8'h09, 32'hBAD0_0008);
    rdb(8'h09);
    chk("dual b", q_b_o, 32'hA9A9_0007);
    wcfg(32'h0000_1808);
    pin(4, 1'b0);
    wra(8'h0A, 32'h5A5A_0009);
    chk("out ce", q_b_o, 32'hA9A9_0007);
    pin(4, 1'b1);
    rdb(8'h0A);
    chk("write side", q_b_o, 32'h5A5A_0009);
    wcfg(32'h0);
    clash(8'h0A, 32'hC0DE_000A, 32'hC0DE_000A);
    axi_rd(4'h4);
    chk("b count", {16'h0, d[31:16]}, 32'h1);
    test_done();
  end
endmodule
